/* File: include/iox_pkg.sv */
// constants, types and carriers of the two-wire eight-bit port expander
// assumes a 25 MHz core clock that samples every pin through a synchroniser
package iox_pkg;

  // core clock and interrupt timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_IV_NS       = 4000;
  localparam int ALERT_MAX_CYC = T_IV_NS / CLK_PERIOD_NS;

  // fixed upper five bits of the seven-bit slave address (0x70 >> 2)
  localparam logic [4:0] ADDR_FIXED = 5'h1c;

  // command byte low bits select the register
  localparam logic [1:0] CMD_INPUT  = 2'h0;
  localparam logic [1:0] CMD_OUTPUT = 2'h1;
  localparam logic [1:0] CMD_INVERT = 2'h2;
  localparam logic [1:0] CMD_DIR    = 2'h3;

  // register reset values (direction bit high means input)
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] OUT_RST = 8'hff;
  localparam logic [7:0] INV_RST = 8'h00;
  localparam logic [7:0] IN_RST  = 8'h00;
  localparam logic [1:0] CMD_RST = 2'h0;

  // bit counter and priming counter end values
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [1:0] PRIME_END = 2'h3;

  // pins that cross into the core clock domain
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       sel_hi;
    logic       sel_lo;
    logic [7:0] port;
  } iox_pins_t;

  localparam int PINS_W = $bits(iox_pins_t);

  // serial bus slot tracker
  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_CMD,
    ST_CACK,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK
  } iox_state_t;

endpackage

/* File: logic/iox_sync.sv */
// two-flop synchroniser for a group of asynchronous pin levels
// assumes the clock enable stays high for the pins to be followed
`timescale 1ns/1ps
module iox_sync #(
  parameter int W = 1
) (
  // clock, reset and enable
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_ce,
  // levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (i_ce) begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule

/* File: logic/iox_top.sv */
// eight-bit port expander: two-wire slave, four registers, change alert
// assumes scl, sda and port pins are asynchronous and reach the core via iox_sync
//
// Overview of operation
// - alert while any input differs from latch
// - slave address from fixed bits plus pins
// - reset pin restores registers and bus state
// - power-on reset equals reset pin effect
// - four eight-bit registers, one bit per pin
// - all pins inputs after power-up
// - direction register bit sets pin direction
// - input latch captures; outputs from output register
// - invert mask flips captured input bits
// - every register readable over the bus
// - alert clears on match or input read
// - output pins and foreign traffic never alert
// - respond to 0x70 plus select pins
// - command byte kept for later reads
`timescale 1ns/1ps
module iox_top
  import iox_pkg::*;
(
  // clock, reset, enable
  input  wire logic       I_REF_CLK,
  input  wire logic       I_ARST_N,
  input  wire logic       I_CE,
  // serial bus
  input  wire logic       I_SCL,
  input  wire logic       I_SDA,
  output logic            O_SDA,
  output logic            O_SDA_OE_N,
  // address select straps
  input  wire logic       I_ADDR_SEL_LO,
  input  wire logic       I_ADDR_SEL_HI,
  // port pins
  input  wire logic [7:0] I_PORT_PINS,
  output logic      [7:0] O_PORT_PINS,
  output logic      [7:0] O_PORT_PINS_OE_N,
  // open-drain change alert
  output logic            O_ALERT,
  output logic            O_ALERT_OE_N
);

  iox_pins_t  pins_a;
  iox_pins_t  pins_s;
  iox_state_t state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic       rw_r;
  logic [1:0] cmd_r;
  logic [7:0] pin_direction_r;
  logic [7:0] pin_output_value_r;
  logic [7:0] input_invert_mask_r;
  logic [7:0] pin_input_value_r;
  logic [1:0] prime_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       sda_oe_n_r;
  logic       alert_oe_n_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic [7:0] live_in;
  logic [7:0] change;
  logic       read_load;
  logic       in_capture;
  logic       wr_commit;
  logic       primed;

  // register selected by the stored command
  function automatic logic [7:0] read_sel(input logic [1:0] cmd, input logic [7:0] live);
    case (cmd)
      CMD_INPUT:  read_sel = live;
      CMD_OUTPUT: read_sel = pin_output_value_r;
      CMD_INVERT: read_sel = input_invert_mask_r;
      default:    read_sel = pin_direction_r;
    endcase
  endfunction

  assign pins_a = '{scl: I_SCL, sda: I_SDA, sel_hi: I_ADDR_SEL_HI, sel_lo: I_ADDR_SEL_LO,
                    port: I_PORT_PINS};

  iox_sync #(
    .W (PINS_W)
  ) u_sync (
    .i_clk    (I_REF_CLK),
    .i_arst_n (I_ARST_N),
    .i_ce     (I_CE),
    .i_async  (pins_a),
    .o_sync   (pins_s)
  );

  // delayed copies of bus lines for edge and condition detection
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (I_CE) begin
      scl_d_r <= pins_s.scl;
      sda_d_r <= pins_s.sda;
    end
  end

  // synchroniser resets low, below the idle bus level: mask edges until primed
  assign primed    = (prime_r == PRIME_END);
  assign scl_rise  = pins_s.scl & ~scl_d_r & primed;
  assign scl_fall  = ~pins_s.scl & scl_d_r & primed;
  assign bus_start = pins_s.scl & scl_d_r & sda_d_r & ~pins_s.sda & primed;
  assign bus_stop  = pins_s.scl & scl_d_r & ~sda_d_r & pins_s.sda & primed;

  // live pin levels through the invert mask
  assign live_in    = pins_s.port ^ input_invert_mask_r;
  // tx byte loads at the rising edge of our ack or the master's ack
  assign read_load  = scl_rise & (((state_r == ST_AACK) & rw_r) |
                                  ((state_r == ST_RACK) & ~pins_s.sda));
  assign in_capture = read_load & (cmd_r == CMD_INPUT);
  assign wr_commit  = scl_rise & (state_r == ST_WDATA) & (bit_cnt_r == LAST_BIT);

  // bus slot tracker, reset by the single reset input
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      shift_r   <= 8'h00;
      rw_r      <= 1'b0;
    end else if (I_CE) begin
      if (bus_start) begin
        state_r   <= ST_ADDR;
        bit_cnt_r <= 3'h0;
      end else if (bus_stop) begin
        state_r <= ST_IDLE;
      end else if (scl_rise) begin
        case (state_r)
          ST_ADDR: begin
            shift_r   <= {shift_r[6:0], pins_s.sda};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            // address compare; foreign traffic goes idle
            if (bit_cnt_r == LAST_BIT) begin
              if (shift_r[6:0] == {ADDR_FIXED, pins_s.sel_hi, pins_s.sel_lo}) begin
                state_r <= ST_AACK;
                rw_r    <= pins_s.sda;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            bit_cnt_r <= 3'h0;
            state_r   <= rw_r ? ST_RDATA : ST_CMD;
          end
          ST_CMD, ST_WDATA: begin
            shift_r   <= {shift_r[6:0], pins_s.sda};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == LAST_BIT) begin
              state_r <= (state_r == ST_CMD) ? ST_CACK : ST_WACK;
            end
          end
          ST_CACK, ST_WACK: begin
            bit_cnt_r <= 3'h0;
            state_r   <= ST_WDATA;
          end
          ST_RDATA: begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == LAST_BIT) begin
              state_r <= ST_RACK;
            end
          end
          ST_RACK: begin
            bit_cnt_r <= 3'h0;
            // a nack ends the read; wait for stop or start
            state_r   <= pins_s.sda ? ST_IDLE : ST_RDATA;
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // command byte kept until the next write transfer
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cmd_r <= CMD_RST;
    end else if (I_CE && scl_rise && state_r == ST_CMD && bit_cnt_r == LAST_BIT) begin
      cmd_r <= {shift_r[0], pins_s.sda}; // upper command bits are ignored
    end
  end

  // writable registers; the input register ignores writes
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pin_direction_r     <= DIR_RST;
      pin_output_value_r  <= OUT_RST;
      input_invert_mask_r <= INV_RST;
    end else if (I_CE && wr_commit) begin
      case (cmd_r)
        CMD_OUTPUT: pin_output_value_r  <= {shift_r[6:0], pins_s.sda};
        CMD_INVERT: input_invert_mask_r <= {shift_r[6:0], pins_s.sda};
        CMD_DIR:    pin_direction_r     <= {shift_r[6:0], pins_s.sda};
        default:    pin_direction_r     <= pin_direction_r;
      endcase
    end
  end

  // transmit byte, reloaded per byte so repeated reads see fresh data
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      tx_r <= 8'h00;
    end else if (I_CE) begin
      if (read_load) begin
        tx_r <= read_sel(cmd_r, live_in);
      end else if (scl_rise && state_r == ST_RDATA) begin
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // input latch: primed after reset, recaptured on input reads
  // priming waits out the synchroniser so reset does not raise a false alert
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      prime_r           <= 2'h0;
      pin_input_value_r <= IN_RST;
    end else if (I_CE) begin
      if (prime_r != PRIME_END) begin
        prime_r           <= prime_r + 2'h1;
        pin_input_value_r <= live_in;
      end else if (in_capture) begin
        pin_input_value_r <= live_in;
      end
    end
  end

  // only input pins can differ from the latch
  assign change = (live_in ^ pin_input_value_r) & pin_direction_r;

  // alert follows the mismatch, so it clears on return or read
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      alert_oe_n_r <= 1'b1;
    end else if (I_CE) begin
      alert_oe_n_r <= ~((prime_r == PRIME_END) & (|change));
    end
  end

  // sda driver changes after scl falls, keeping data stable while high; a start or stop releases it at once
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sda_oe_n_r <= 1'b1;
    end else if (I_CE) begin
      if (bus_start || bus_stop) begin
        sda_oe_n_r <= 1'b1;
      end else if (scl_fall) begin
        case (state_r)
          ST_AACK, ST_CACK, ST_WACK: sda_oe_n_r <= 1'b0;
          ST_RDATA:                  sda_oe_n_r <= tx_r[7];
          default:                   sda_oe_n_r <= 1'b1;
        endcase
      end
    end
  end

  // open-drain lines only ever pull low
  assign O_SDA        = 1'b0;
  assign O_ALERT      = 1'b0;
  assign O_SDA_OE_N   = sda_oe_n_r;
  assign O_ALERT_OE_N = alert_oe_n_r;
  // output driver from latched values, off for input pins
  assign O_PORT_PINS      = pin_output_value_r;
  assign O_PORT_PINS_OE_N = pin_direction_r;

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);

  property p_alert_set;
    (I_CE && prime_r == PRIME_END && |change) ##1 I_CE |-> !O_ALERT_OE_N;
  endproperty
  a_alert_set : assert property (p_alert_set) else $error("alert missing");

  property p_out_no_alert;
    (I_CE && ((live_in ^ pin_input_value_r) & pin_direction_r) == 8'h00) ##1 I_CE
      |-> O_ALERT_OE_N;
  endproperty
  a_out_no_alert : assert property (p_out_no_alert) else $error("false alert");

  property p_addr_match;
    (state_r == ST_AACK && $past(state_r) == ST_ADDR)
      |-> shift_r[7:1] == {ADDR_FIXED, pins_s.sel_hi, pins_s.sel_lo};
  endproperty
  a_addr_match : assert property (p_addr_match) else $error("wrong address acked");

  property p_cmd_hold;
    $changed(cmd_r) |-> $past(state_r) == ST_CMD;
  endproperty
  a_cmd_hold : assert property (p_cmd_hold) else $error("command changed");

  property p_dir_write;
    (I_CE && wr_commit && cmd_r == CMD_DIR)
      |=> O_PORT_PINS_OE_N == {$past(shift_r[6:0]), $past(pins_s.sda)};
  endproperty
  a_dir_write : assert property (p_dir_write) else $error("direction not written");

  property p_input_read;
    (I_CE && in_capture) |=> pin_input_value_r == $past(live_in) && tx_r == $past(live_in);
  endproperty
  a_input_read : assert property (p_input_read) else $error("input read wrong");

  property p_invert;
    (I_CE && in_capture) |=> pin_input_value_r == ($past(pins_s.port) ^ input_invert_mask_r);
  endproperty
  a_invert : assert property (p_invert) else $error("invert not applied");

  property p_readback;
    (I_CE && read_load && cmd_r == CMD_OUTPUT) |=> tx_r == O_PORT_PINS;
  endproperty
  a_readback : assert property (p_readback) else $error("readback wrong");

  property p_ack_hold;
    (state_r == ST_AACK && !sda_oe_n_r) |-> ##1 (!sda_oe_n_r || state_r != ST_AACK);
  endproperty
  a_ack_hold : assert property (p_ack_hold) else $error("ack dropped early");

  c_read  : cover property (in_capture);
  c_write : cover property (wr_commit && cmd_r == CMD_OUTPUT);
  c_alert : cover property ($fell(O_ALERT_OE_N) ##[1:1000] $rose(O_ALERT_OE_N));

endmodule

/* File: verif/iox_master.sv */
// behavioural two-wire bus master for the expander's serial pins
// assumes the bench resolves sda as a wired-and with a pull-up
`timescale 1ns/1ps
module iox_master (
  // clock and wire level
  input  wire logic i_clk,
  input  wire logic i_sda,
  // driven lines, high means released
  output logic      o_scl,
  output logic      o_sda
);
  // scl stands high between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // quarter bit of two cycles keeps scl high and low four cycles each
  task automatic qb();
    repeat (2) @(negedge i_clk);
  endtask
  // start or repeated start; sda rises while scl is low, then falls while scl is high
  task automatic start();
    qb();
    o_sda = 1'b1;
    qb();
    o_scl = 1'b1;
    qb();
    o_sda = 1'b0;
    qb();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    qb();
    o_sda = 1'b0;
    qb();
    o_scl = 1'b1;
    qb();
    o_sda = 1'b1;
    qb();
  endtask
  // one slot, sampled in the middle of the high phase
  task automatic bit_slot(input logic b, output logic v);
    qb();
    o_sda = b;
    qb();
    o_scl = 1'b1;
    qb();
    v = i_sda;
    qb();
    o_scl = 1'b0;
  endtask
  // byte out msb first, ack slot left released
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], v);
    end
    bit_slot(1'b1, ack);
  endtask
  // byte in msb first; nack high ends the read
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, v);
      d[i] = v;
    end
    bit_slot(nack, v);
  endtask
endmodule

/* File: verif/tb_iox_top.sv */
// self-checking bench of the port expander through its two-wire bus
// assumes pull-ups on sda and on pins that nobody drives
`timescale 1ns/1ps
module tb_iox_top
  import iox_pkg::*;
;
  logic       clk          = 1'b0;
  logic       arst_n       = 1'b0;
  logic       scl_m;
  logic       sda_m;
  logic       sda_o;
  logic       sda_oe_n;
  logic       alert_oe_n;
  logic       alert_o;
  logic       ce           = 1'b1;
  logic [7:0] ext          = 8'h3c;
  logic [7:0] pout;
  logic [7:0] poe_n;
  logic [7:0] e_dir        = DIR_RST;
  logic [7:0] e_out        = OUT_RST;
  logic [7:0] e_inv        = INV_RST;
  logic [6:0] addr         = {ADDR_FIXED, 2'h2};
  int         err_count    = 0;
  int         total_checks = 0;
  int         cyc          = 0;
  // wired-and bus and pin levels from every driver
  wire        sda_w = sda_m & (sda_oe_n | sda_o);
  wire  [7:0] pins  = (~poe_n & pout) | (poe_n & ext);

  iox_top u_iox_top (
    .I_REF_CLK(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_SCL(scl_m), .I_SDA(sda_w),
    .O_SDA(sda_o), .O_SDA_OE_N(sda_oe_n), .I_ADDR_SEL_LO(addr[0]),
    .I_ADDR_SEL_HI(addr[1]), .I_PORT_PINS(pins), .O_PORT_PINS(pout),
    .O_PORT_PINS_OE_N(poe_n), .O_ALERT(alert_o), .O_ALERT_OE_N(alert_oe_n));
  iox_master u_iox_master (.i_clk(clk), .i_sda(sda_w), .o_scl(scl_m), .o_sda(sda_m));

  initial begin
    forever #20 clk = ~clk;
  end
  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // expected input register: pin level through the invert mask
  function automatic logic [7:0] inx();
    return ((e_dir & ext) | (~e_dir & e_out)) ^ e_inv;
  endfunction
  // ack_n high means the address is expected to be refused
  task automatic wr_reg(input logic [6:0] a, input logic [1:0] cmd, input logic [7:0] d,
                        input logic ack_n);
    logic k;
    u_iox_master.start();
    u_iox_master.wr_byte({a, 1'b0}, k);
    chk("addr ack", {7'h0, ack_n}, {7'h0, k});
    if (!ack_n) begin
      u_iox_master.wr_byte({6'h0, cmd}, k);
      chk("cmd ack", 8'h0, {7'h0, k});
      u_iox_master.wr_byte(d, k);
      chk("data ack", 8'h0, {7'h0, k});
      case (cmd)
        CMD_OUTPUT: e_out = d;
        CMD_INVERT: e_inv = d;
        CMD_DIR:    e_dir = d;
        default:    e_dir = e_dir;
      endcase
    end
    u_iox_master.stop();
  endtask
  // set low reads from the stored command without sending one
  task automatic rd(input logic set, input logic [1:0] cmd, input logic [7:0] exp);
    logic       k;
    logic [7:0] d;
    u_iox_master.start();
    if (set) begin
      u_iox_master.wr_byte({addr, 1'b0}, k);
      u_iox_master.wr_byte({6'h0, cmd}, k);
      u_iox_master.start();
    end
    u_iox_master.wr_byte({addr, 1'b1}, k);
    chk("read ack", 8'h0, {7'h0, k});
    u_iox_master.rd_byte(1'b1, d);
    u_iox_master.stop();
    chk("read data", exp, d);
  endtask
  // two bytes in one read; the master's ack reloads the same register
  task automatic rd2(input logic [7:0] exp);
    logic       k;
    logic [7:0] d;
    u_iox_master.start();
    u_iox_master.wr_byte({addr, 1'b1}, k);
    chk("read ack", 8'h0, {7'h0, k});
    u_iox_master.rd_byte(1'b0, d);
    chk("read data", exp, d);
    u_iox_master.rd_byte(1'b1, d);
    chk("read data 2", exp, d);
    u_iox_master.stop();
  endtask
  // alert settles within five cycles of a pin change
  task automatic al(input logic exp);
    repeat (8) @(negedge clk);
    chk("alert", {7'h0, exp}, {7'h0, alert_oe_n | alert_o});
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    e_dir  = DIR_RST;
    e_out  = OUT_RST;
    e_inv  = INV_RST;
    repeat (2) @(negedge clk);
    chk("pins oe", DIR_RST, poe_n);
    chk("pins out", OUT_RST, pout);
    arst_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask

  initial begin
    do_reset();
    rd(0, CMD_INPUT, inx());
    rd(1, CMD_OUTPUT, OUT_RST);
    rd(1, CMD_INVERT, INV_RST);
    rd(1, CMD_DIR, DIR_RST);
    al(1'b1);
    wr_reg({ADDR_FIXED, 2'h1}, CMD_DIR, 8'h00, 1'b1);
    chk("pins oe", DIR_RST, poe_n);
    wr_reg(addr, CMD_DIR, 8'h0f, 1'b0);
    wr_reg(addr, CMD_OUTPUT, 8'ha5, 1'b0);
    chk("pins oe", 8'h0f, poe_n);
    chk("pins out", 8'ha5, pout);
    wr_reg(addr, CMD_INVERT, 8'h33, 1'b0);
    rd(1, CMD_INPUT, inx());
    rd(0, CMD_INPUT, inx());
    rd(1, CMD_DIR, 8'h0f);
    rd2(8'h0f);
    rd(0, CMD_INPUT, 8'h0f);
    // alert set, kept over foreign traffic, cleared by match and by read
    ext[0] = ~ext[0];
    al(1'b0);
    wr_reg({ADDR_FIXED, 2'h3}, CMD_INPUT, 8'h00, 1'b1);
    al(1'b0);
    ext[0] = ~ext[0];
    al(1'b1);
    ext[1] = ~ext[1];
    al(1'b0);
    rd(1, CMD_INPUT, inx());
    al(1'b1);
    wr_reg(addr, CMD_OUTPUT, 8'h5a, 1'b0);
    al(1'b1);
    // mid-run reset restores registers and the stored command
    do_reset();
    rd(0, CMD_INPUT, inx());
    rd(1, CMD_DIR, DIR_RST);
    // a write to the input register is acked, changes nothing, selects reads
    wr_reg(addr, CMD_INPUT, 8'hc3, 1'b0);
    chk("pins oe", DIR_RST, poe_n);
    rd(0, CMD_INPUT, inx());
    // frozen core ignores a pin change until the enable returns
    ce     = 1'b0;
    ext[2] = ~ext[2];
    al(1'b1);
    ce     = 1'b1;
    al(1'b0);
    ext[2] = ~ext[2];
    al(1'b1);
    stop_test();
  end
endmodule
